//--- src/mtx_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef MTX_CFG_SVH
`define MTX_CFG_SVH
// device register offsets
`define MTX_CTRL_OFS 12'h200
`define MTX_BASE_OFS 12'h208
`define MTX_LAST_OFS 12'h210
`define MTX_HEAD_OFS 12'h220
`define MTX_TAIL_OFS 12'h228
// control fields
`define MTX_EN_BIT 0
`define MTX_RB_BIT 1
`define MTX_RF_BIT 2
`define MTX_REG_RST 32'h0000_0000
// packet header line: payload line count in the low bits
`define MTX_HDR_LEN_W 16
// controller own register offsets
`define FW_CMD_OFS 8'h00
`define FW_BASE_OFS 8'h04
`define FW_LAST_OFS 8'h08
`define FW_DATA_OFS 8'h0C
`define FW_PUSH_OFS 8'h10
`define FW_STAT_OFS 8'h14
`define FW_WPTR_OFS 8'h18
// controller order codes
`define FW_CMD_ENABLE 32'h0000_0001
`define FW_CMD_RESET 32'h0000_0002
`define FW_CMD_COMMIT 32'h0000_0003
// timing
`define MTX_CLK_HZ 50000000
`define MTX_HOLD_MS 2
`define MTX_HOLD_CYC ((`MTX_HOLD_MS * `MTX_CLK_HZ) / 1000)
`endif

//--- src/mtx_pkg.sv
// shared types and pointer arithmetic of the transmit ring
package mtx_pkg;
  typedef logic [27:0] line_t;
  typedef enum logic [1:0] {D_IDLE, D_HDR, D_SEND} dev_st_t;
  typedef enum logic [2:0] {F_IDLE, F_RST1, F_RST2, F_RST3} fw_st_t;

  // step one memory line, wrapping from the last line to the base
  function automatic line_t next_line(line_t p, line_t base, line_t last);
    return (p == last) ? base : line_t'(p + 28'h1);
  endfunction
endpackage

//--- src/mtx_if.sv
// register and buffer-memory link between firmware end and ring device
`timescale 1ns/1ps
interface mtx_if #(parameter int LINE_W = 128) ();
  logic [11:0]       reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              mem_wr;
  logic [31:0]       mem_addr;
  logic [LINE_W-1:0] mem_wdata;

  modport dev (
    input  reg_addr,
    input  reg_wdata,
    input  reg_wr,
    input  reg_rd,
    output reg_rdata,
    input  mem_wr,
    input  mem_addr,
    input  mem_wdata
  );
  modport fw (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input  reg_rdata,
    output mem_wr,
    output mem_addr,
    output mem_wdata
  );
endinterface

//--- src/mtx_ring_dev.sv
// management transmit ring buffer: registers, line memory, packet streamer
`timescale 1ns/1ps
`include "mtx_cfg.svh"
module mtx_ring_dev #(
  parameter int LINE_W    = 128,
  parameter int MEM_LINES = 1024
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  mtx_if.dev                     bus,
  input  wire logic              TX_READY_I,
  output logic [LINE_W-1:0]      TX_DATA_O,
  output logic                   TX_VALID_O,
  output logic                   TX_LAST_O,
  output logic                   TX_ABORT_O
);
  localparam int AW = $clog2(MEM_LINES);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (LINE_W < `MTX_HDR_LEN_W) begin : g_bad_width
    $error("line width cannot carry the packet header");
  end
  if (MEM_LINES < 4 || (1 << AW) != MEM_LINES) begin : g_bad_depth
    $error("memory depth must be a power of two of at least four");
  end

  typedef struct packed {
    logic                     en;
    logic                     rb;
    logic                     rf;
    mtx_pkg::line_t           base;
    logic [25:0]              last;
    mtx_pkg::line_t           head;
    mtx_pkg::line_t           tail;
    mtx_pkg::line_t           rd;
    logic [`MTX_HDR_LEN_W-1:0] cnt;
    mtx_pkg::dev_st_t         st;
    logic [LINE_W-1:0]        tx_data;
    logic                     tx_valid;
    logic                     tx_last;
    logic                     tx_abort;
    logic [31:0]              rdata;
  } dev_state_t;

  dev_state_t         s_r;
  dev_state_t         s_nxt;
  logic [LINE_W-1:0]  mem [MEM_LINES];
  logic [LINE_W-1:0]  mem_line;
  mtx_pkg::line_t     last_line;
  mtx_pkg::line_t     rd_next;

  // ----------------------------------------------------------------
  // line memory, written by firmware
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (bus.mem_wr) begin
      mem[bus.mem_addr[AW+3:4]] <= bus.mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.tx_abort = 1'b0;
    s_nxt.rdata    = 32'h0000_0000;
    mem_line       = mem[s_r.rd[AW-1:0]];
    // the last line is the final 16-byte line of the 64-byte block
    last_line      = {s_r.last, 2'h3};
    rd_next        = mtx_pkg::next_line(s_r.rd, s_r.base, last_line);

    // packet streamer
    case (s_r.st)
      mtx_pkg::D_IDLE: begin
        if (s_r.en && (s_r.tail != s_r.head)) begin
          s_nxt.rd = s_r.tail;
          s_nxt.st = mtx_pkg::D_HDR;
        end
      end
      mtx_pkg::D_HDR: begin
        s_nxt.cnt = mem_line[`MTX_HDR_LEN_W-1:0];
        s_nxt.rd  = rd_next;
        if (mem_line[`MTX_HDR_LEN_W-1:0] == '0) begin
          s_nxt.tail = rd_next;
          s_nxt.st   = mtx_pkg::D_IDLE;
        end else begin
          s_nxt.st = mtx_pkg::D_SEND;
        end
      end
      mtx_pkg::D_SEND: begin
        if (s_r.tx_valid && TX_READY_I && s_r.tx_last) begin
          // whole packet handed over: release its lines
          s_nxt.tx_valid = 1'b0;
          s_nxt.tx_last  = 1'b0;
          s_nxt.tail     = s_r.rd;
          s_nxt.st       = mtx_pkg::D_IDLE;
        end else if (!s_r.tx_valid || TX_READY_I) begin
          if (s_r.cnt != '0) begin
            s_nxt.tx_data  = mem_line;
            s_nxt.tx_valid = 1'b1;
            s_nxt.tx_last  = (s_r.cnt == `MTX_HDR_LEN_W'(1));
            s_nxt.cnt      = s_r.cnt - `MTX_HDR_LEN_W'(1);
            s_nxt.rd       = rd_next;
          end else begin
            s_nxt.tx_valid = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = mtx_pkg::D_IDLE;
      end
    endcase

    // self-clearing controls act in the cycle after they are written
    if (s_r.rf) begin
      s_nxt.st       = mtx_pkg::D_IDLE;
      s_nxt.tx_valid = 1'b0;
      s_nxt.tx_last  = 1'b0;
      s_nxt.tx_data  = '0;
      s_nxt.cnt      = '0;
    end
    if (s_r.rb) begin
      s_nxt.tx_abort = (s_r.st == mtx_pkg::D_SEND);
      s_nxt.st       = mtx_pkg::D_IDLE;
      s_nxt.tx_valid = 1'b0;
      s_nxt.tx_last  = 1'b0;
      s_nxt.head     = s_r.base;
      s_nxt.tail     = s_r.base;
    end
    s_nxt.rb = 1'b0;
    s_nxt.rf = 1'b0;

    // register writes
    if (bus.reg_wr) begin
      case (bus.reg_addr)
        `MTX_CTRL_OFS: begin
          s_nxt.en = bus.reg_wdata[`MTX_EN_BIT];
          s_nxt.rb = bus.reg_wdata[`MTX_RB_BIT];
          s_nxt.rf = bus.reg_wdata[`MTX_RF_BIT];
        end
        `MTX_BASE_OFS: begin
          s_nxt.base = bus.reg_wdata[31:4];
          s_nxt.head = bus.reg_wdata[31:4];
          s_nxt.tail = bus.reg_wdata[31:4];
        end
        `MTX_LAST_OFS: begin
          s_nxt.last = bus.reg_wdata[31:6];
        end
        `MTX_HEAD_OFS: begin
          s_nxt.head = bus.reg_wdata[31:4];
        end
        default: begin
          // tail and unmapped offsets ignore writes
          s_nxt.en = s_nxt.en;
        end
      endcase
    end

    // register reads, answered in the next cycle
    if (bus.reg_rd) begin
      case (bus.reg_addr)
        `MTX_CTRL_OFS: s_nxt.rdata = {29'h0000_0000, s_r.rf, s_r.rb, s_r.en};
        `MTX_BASE_OFS: s_nxt.rdata = {s_r.base, 4'h0};
        `MTX_LAST_OFS: s_nxt.rdata = {s_r.last, 6'h00};
        `MTX_HEAD_OFS: s_nxt.rdata = {s_r.head, 4'h0};
        `MTX_TAIL_OFS: s_nxt.rdata = {s_r.tail, 4'h0};
        default:       s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r    <= '0;
      s_r.st <= mtx_pkg::D_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.reg_rdata = s_r.rdata;
  assign TX_DATA_O     = s_r.tx_data;
  assign TX_VALID_O    = s_r.tx_valid;
  assign TX_LAST_O     = s_r.tx_last;
  assign TX_ABORT_O    = s_r.tx_abort;
endmodule // mtx_ring_dev

//--- src/mtx_fw_end.sv
// firmware end: fills the ring, commits packets, sequences resets
`timescale 1ns/1ps
`include "mtx_cfg.svh"
module mtx_fw_end #(
  parameter int LINE_W   = 128,
  parameter int HOLD_CYC = `MTX_HOLD_CYC
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O,
  mtx_if.fw                bus
);
  localparam int HW = $clog2(HOLD_CYC + 1);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (LINE_W < 64 || (LINE_W % 32) != 0) begin : g_bad_width
    $error("line width must be a multiple of 32 of at least 64");
  end
  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("hold-off count must be at least one");
  end

  typedef struct packed {
    mtx_pkg::fw_st_t   st;
    logic              en;
    mtx_pkg::line_t    base;
    logic [25:0]       last;
    mtx_pkg::line_t    wp;
    mtx_pkg::line_t    tail;
    logic [LINE_W-1:0] stage;
    logic [HW-1:0]     hold;
    logic              refused;
    logic [1:0]        poll;
    logic [11:0]       reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic              mem_wr;
    logic [31:0]       mem_addr;
    logic [LINE_W-1:0] mem_wdata;
    logic [31:0]       rdata;
  } fw_state_t;

  fw_state_t      s_r;
  fw_state_t      s_nxt;
  mtx_pkg::line_t wp_next;
  logic           addr_lock;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.reg_wr = 1'b0;
    s_nxt.reg_rd = 1'b0;
    s_nxt.mem_wr = 1'b0;
    s_nxt.rdata  = 32'h0000_0000;
    wp_next      = mtx_pkg::next_line(s_r.wp, s_r.base, {s_r.last, 2'h3});
    addr_lock    = s_r.en || (s_r.hold != '0);
    if (s_r.hold != '0) begin
      s_nxt.hold = s_r.hold - HW'(1);
    end
    // a status read clears the sticky refusal; a refusal in the same cycle wins
    if (RD_I && (ADDR_I == `FW_STAT_OFS)) begin
      s_nxt.refused = 1'b0;
    end

    case (s_r.st)
      mtx_pkg::F_IDLE: begin
        if (WR_I) begin
          case (ADDR_I)
            `FW_BASE_OFS: begin
              if (addr_lock) begin
                s_nxt.refused = 1'b1;
              end else begin
                s_nxt.base      = WDATA_I[31:4];
                s_nxt.wp        = WDATA_I[31:4];
                s_nxt.tail      = WDATA_I[31:4];
                s_nxt.reg_wr    = 1'b1;
                s_nxt.reg_addr  = `MTX_BASE_OFS;
                s_nxt.reg_wdata = {WDATA_I[31:4], 4'h0};
              end
            end
            `FW_LAST_OFS: begin
              if (addr_lock) begin
                s_nxt.refused = 1'b1;
              end else begin
                s_nxt.last      = WDATA_I[31:6];
                s_nxt.reg_wr    = 1'b1;
                s_nxt.reg_addr  = `MTX_LAST_OFS;
                s_nxt.reg_wdata = {WDATA_I[31:6], 6'h00};
              end
            end
            `FW_DATA_OFS: begin
              s_nxt.stage = {s_r.stage[LINE_W-33:0], WDATA_I};
            end
            `FW_PUSH_OFS: begin
              if (wp_next == s_r.tail) begin
                s_nxt.refused = 1'b1;
              end else begin
                s_nxt.mem_wr    = 1'b1;
                s_nxt.mem_addr  = {s_r.wp, 4'h0};
                s_nxt.mem_wdata = s_r.stage;
                s_nxt.wp        = wp_next;
              end
            end
            `FW_CMD_OFS: begin
              case (WDATA_I)
                `FW_CMD_ENABLE: begin
                  s_nxt.en        = 1'b1;
                  s_nxt.reg_wr    = 1'b1;
                  s_nxt.reg_addr  = `MTX_CTRL_OFS;
                  s_nxt.reg_wdata = 32'h0000_0001;
                end
                `FW_CMD_RESET: begin
                  s_nxt.st = mtx_pkg::F_RST1;
                end
                `FW_CMD_COMMIT: begin
                  // the head moves to the write pointer, over every line pushed so far
                  s_nxt.reg_wr    = 1'b1;
                  s_nxt.reg_addr  = `MTX_HEAD_OFS;
                  s_nxt.reg_wdata = {s_r.wp, 4'h0};
                end
                default: begin
                  s_nxt.refused = 1'b1;
                end
              endcase
            end
            default: begin
              // other offsets ignore writes
            end
          endcase
        end
      end
      mtx_pkg::F_RST1: begin
        // abort first, enable still as it was
        s_nxt.reg_wr    = 1'b1;
        s_nxt.reg_addr  = `MTX_CTRL_OFS;
        s_nxt.reg_wdata = {29'h0000_0000, 1'b0, 1'b1, s_r.en};
        s_nxt.st        = mtx_pkg::F_RST2;
      end
      mtx_pkg::F_RST2: begin
        s_nxt.en        = 1'b0;
        s_nxt.reg_wr    = 1'b1;
        s_nxt.reg_addr  = `MTX_CTRL_OFS;
        s_nxt.reg_wdata = 32'h0000_0000;
        s_nxt.st        = mtx_pkg::F_RST3;
      end
      mtx_pkg::F_RST3: begin
        s_nxt.reg_wr    = 1'b1;
        s_nxt.reg_addr  = `MTX_CTRL_OFS;
        s_nxt.reg_wdata = 32'h0000_0006;
        s_nxt.wp        = s_r.base;
        s_nxt.tail      = s_r.base;
        s_nxt.hold      = HW'(HOLD_CYC);
        s_nxt.st        = mtx_pkg::F_IDLE;
      end
      default: begin
        s_nxt.st = mtx_pkg::F_IDLE;
      end
    endcase
    if (WR_I && s_r.st != mtx_pkg::F_IDLE) begin
      s_nxt.refused = 1'b1;
    end

    // tail poll: strobe, wait, capture; skipped when a write holds the bus
    case (s_r.poll)
      2'h0: begin
        if (!s_nxt.reg_wr) begin
          s_nxt.reg_rd   = 1'b1;
          s_nxt.reg_addr = `MTX_TAIL_OFS;
          s_nxt.poll     = 2'h1;
        end
      end
      2'h1: s_nxt.poll = 2'h2;
      default: begin
        s_nxt.tail = bus.reg_rdata[31:4];
        s_nxt.poll = 2'h0;
      end
    endcase

    // software reads
    if (RD_I) begin
      case (ADDR_I)
        `FW_STAT_OFS: begin
          s_nxt.rdata = {28'h0000000, s_r.hold != '0, s_r.st != mtx_pkg::F_IDLE,
                         s_r.refused, s_r.en};
        end
        `FW_WPTR_OFS: s_nxt.rdata = {s_r.wp, 4'h0};
        `FW_BASE_OFS: s_nxt.rdata = {s_r.base, 4'h0};
        `FW_LAST_OFS: s_nxt.rdata = {s_r.last, 6'h00};
        default:      s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r      <= '0;
      s_r.st   <= mtx_pkg::F_IDLE;
      s_r.hold <= HW'(HOLD_CYC);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA_O       = s_r.rdata;
  assign bus.reg_addr  = s_r.reg_addr;
  assign bus.reg_wdata = s_r.reg_wdata;
  assign bus.reg_wr    = s_r.reg_wr;
  assign bus.reg_rd    = s_r.reg_rd;
  assign bus.mem_wr    = s_r.mem_wr;
  assign bus.mem_addr  = s_r.mem_addr;
  assign bus.mem_wdata = s_r.mem_wdata;
endmodule // mtx_fw_end

//--- sim/mtx_ring_monitor.sv
// concurrent checks on the firmware-to-device link and the transmit stream
`timescale 1ns/1ps
`include "mtx_cfg.svh"
module mtx_ring_monitor #(
  parameter int LINE_W   = 128,
  parameter int HOLD_CYC = 20
) (
  input wire logic              CLK_I,
  input wire logic              RST_I,
  input wire logic [11:0]       reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              mem_wr,
  input wire logic [31:0]       mem_addr,
  input wire logic [LINE_W-1:0] mem_wdata,
  input wire logic              TX_READY_I,
  input wire logic [LINE_W-1:0] TX_DATA_O,
  input wire logic              TX_VALID_O,
  input wire logic              TX_LAST_O,
  input wire logic              TX_ABORT_O
);
  default clocking mon_cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic        ctrl_wr, rb_wr, rst_wr, addr_wr, tail_rd, pkt_end;
  logic        en_r, pkt_r, quiet_r, rd_r, trust_r;
  logic [1:0]  stale_r;
  logic [31:0] base_r, tail_r;
  int          hold_r;
  assign ctrl_wr = reg_wr && (reg_addr == `MTX_CTRL_OFS);
  assign rb_wr   = ctrl_wr && reg_wdata[`MTX_RB_BIT];
  assign rst_wr  = ctrl_wr && (reg_wdata[`MTX_RB_BIT] || reg_wdata[`MTX_RF_BIT]);
  assign addr_wr = reg_wr && (reg_addr == `MTX_BASE_OFS || reg_addr == `MTX_LAST_OFS);
  assign tail_rd = reg_rd && (reg_addr == `MTX_TAIL_OFS);
  assign pkt_end = TX_VALID_O && TX_READY_I && TX_LAST_O;
  // tail readbacks are trusted only once any pointer change has settled
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      en_r    <= 1'b0;
      pkt_r   <= 1'b0;
      quiet_r <= 1'b1;
      rd_r    <= 1'b0;
      trust_r <= 1'b0;
      stale_r <= 2'h3;
      base_r  <= 32'h0000_0000;
      tail_r  <= 32'h0000_0000;
      hold_r  <= HOLD_CYC - 1;
    end else begin
      rd_r <= tail_rd;
      if (ctrl_wr) en_r <= reg_wdata[`MTX_EN_BIT];
      if (TX_VALID_O) pkt_r <= !(TX_READY_I && TX_LAST_O);
      else if (TX_ABORT_O) pkt_r <= 1'b0;
      if (reg_wr && reg_addr == `MTX_BASE_OFS) begin
        base_r  <= reg_wdata;
        quiet_r <= 1'b1;
      end else if (ctrl_wr && reg_wdata[`MTX_EN_BIT]) quiet_r <= 1'b0;
      if (rst_wr || (ctrl_wr && en_r && !reg_wdata[`MTX_EN_BIT])) hold_r <= HOLD_CYC - 1;
      else if (hold_r != 0) hold_r <= hold_r - 1;
      // any register write may move the tail soon after (empty packets skip output)
      if (reg_wr || pkt_end) begin
        stale_r <= 2'h3;
        trust_r <= 1'b0;
      end else if (stale_r != 2'h0) stale_r <= stale_r - 2'h1;
      else if (rd_r) begin
        trust_r <= 1'b1;
        tail_r  <= reg_rdata;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_EN_GATE: assert property ($rose(TX_VALID_O) && !pkt_r |-> en_r)
    else $error("packet started while transmit disabled");
  AST_ADDR_WHILE_OFF: assert property (addr_wr |-> !en_r)
    else $error("buffer address written while enabled");
  AST_RB_ABORT: assert property (rb_wr ##1 TX_VALID_O |=> TX_ABORT_O && !TX_VALID_O)
    else $error("reset buffer did not abort the packet in flight");
  AST_RB_WITH_RF: assert property (
    ctrl_wr && reg_wdata[`MTX_RF_BIT] |-> reg_wdata[`MTX_RB_BIT])
    else $error("reset fifo written without reset buffer");
  AST_RF_DISABLED: assert property (
    ctrl_wr && reg_wdata[`MTX_RF_BIT] |-> !en_r && !reg_wdata[0])
    else $error("reset fifo while transmit enabled");
  AST_RB_BEFORE_OFF: assert property (ctrl_wr && en_r && !reg_wdata[0] |-> $past(rb_wr))
    else $error("enable cleared without prior reset buffer");
  AST_ABORT_CAUSE: assert property (TX_ABORT_O |-> $past(rb_wr, 2) ##1 !TX_ABORT_O)
    else $error("abort pulse without reset buffer or too long");
  AST_BASE_LOAD: assert property (
    rd_r && quiet_r && stale_r == 2'h0 |-> reg_rdata == {base_r[31:4], 4'h0})
    else $error("tail does not hold the written base");
  AST_HOLD_OFF: assert property (addr_wr |-> hold_r == 0)
    else $error("buffer address written inside hold-off time");
  AST_TAIL_STEP: assert property (
    rd_r && trust_r && stale_r == 2'h0 |-> reg_rdata == tail_r)
    else $error("tail moved without a packet end");
  AST_VALID_HOLD: assert property (
    TX_VALID_O && !TX_READY_I && !$past(rst_wr) |=>
    TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O))
    else $error("stream line changed before acceptance");
  COV_ABORT: cover property (rb_wr ##2 TX_ABORT_O);
  COV_PKT_END: cover property (pkt_end);
  COV_ADDR_WR: cover property (addr_wr && hold_r == 0 && !mem_wr);
endmodule // mtx_ring_monitor

//--- sim/test_mgmt_tx_ring_buffer.sv
// self-checking bench: firmware end and ring device joined by their link
`timescale 1ns/1ps
`include "mtx_cfg.svh"
module test_mgmt_tx_ring_buffer;
  localparam int HOLD = 20;
  logic         CLK_I, RST_I, WR_I, RD_I, TX_READY_I, TX_VALID_O, TX_LAST_O, TX_ABORT_O, rdy_on;
  logic [7:0]   ADDR_I;
  logic [31:0]  WDATA_I, RDATA_O, st;
  logic [127:0] TX_DATA_O;
  logic [128:0] exp_q[$];
  int           mismatches, checks, aborts, n;
  mtx_if #(.LINE_W(128)) link ();
  mtx_fw_end #(.LINE_W(128), .HOLD_CYC(HOLD)) i_mtx_fw_end (.CLK_I(CLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .bus(link));
  mtx_ring_dev #(.LINE_W(128), .MEM_LINES(1024)) i_mtx_ring_dev (.CLK_I(CLK_I), .RST_I(RST_I),
    .bus(link), .TX_READY_I(TX_READY_I), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O),
    .TX_LAST_O(TX_LAST_O), .TX_ABORT_O(TX_ABORT_O));
  mtx_ring_monitor #(.LINE_W(128), .HOLD_CYC(HOLD)) i_mtx_ring_monitor (.CLK_I(CLK_I),
    .RST_I(RST_I), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .mem_wr(link.mem_wr),
    .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata), .TX_READY_I(TX_READY_I),
    .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_LAST_O(TX_LAST_O), .TX_ABORT_O(TX_ABORT_O));
  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [128:0] got, input logic [128:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // stream sink: random back-pressure, every accepted line compared in order
  always @(posedge CLK_I) begin
    if (!RST_I && TX_ABORT_O) aborts++;
    if (!RST_I && TX_VALID_O && TX_READY_I) begin
      if (exp_q.size() == 0) chk({TX_LAST_O, TX_DATA_O}, 129'h0);
      else chk({TX_LAST_O, TX_DATA_O}, exp_q.pop_front());
    end
    TX_READY_I <= rdy_on && ($urandom % 4 != 0);
  end
  // ----------------------------------------------------------------
  // software port tasks
  // ----------------------------------------------------------------
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    ADDR_I  <= a;
    WDATA_I <= d;
    WR_I    <= 1'b1;
    @(posedge CLK_I);
    WR_I    <= 1'b0;
  endtask
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    @(posedge CLK_I);
    RD_I   <= 1'b0;
    #1;
    d = RDATA_O;
  endtask
  // reads status (which clears the sticky refusal) and returns {refused, enabled}
  task automatic stat(output logic [1:0] s);
    logic [31:0] d;
    sw_rd(`FW_STAT_OFS, d);
    s = d[1:0];
  endtask
  task automatic push_line(input logic [127:0] w);
    for (int i = 0; i < 4; i++) sw_wr(`FW_DATA_OFS, w[127 - 32 * i -: 32]);
    sw_wr(`FW_PUSH_OFS, 32'h0000_0000);
  endtask
  // header line carries the payload line count; expectations queued before commit
  task automatic send_pkt(input int len);
    logic [127:0] w;
    push_line({112'h0, 16'(len)});
    for (int i = 0; i < len; i++) begin
      w = {$urandom, $urandom, $urandom, $urandom};
      exp_q.push_back({i == len - 1, w});
      push_line(w);
    end
    sw_wr(`FW_CMD_OFS, `FW_CMD_COMMIT);
  endtask
  task automatic wait_drain();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 3000) begin
      @(posedge CLK_I);
      k++;
    end
    if (k >= 3000) begin
      mismatches++;
      $display("unexpected stall at %0t: got %h expected %h", $time, exp_q.size(), 0);
      test_done();
    end
    repeat (12) @(posedge CLK_I);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] s;
    RST_I      = 1'b1;
    WR_I       = 1'b0;
    RD_I       = 1'b0;
    ADDR_I     = 8'h00;
    WDATA_I    = 32'h0000_0000;
    rdy_on     = 1'b0;
    mismatches = 0;
    checks     = 0;
    aborts     = 0;
    void'($urandom(32'h7bcd150c));
    repeat (10) @(posedge CLK_I);
    RST_I <= 1'b0;
    sw_wr(`FW_BASE_OFS, 32'h0000_1000);
    stat(s);
    chk(129'(s), 129'h2);
    repeat (HOLD + 5) @(posedge CLK_I);
    sw_wr(`FW_BASE_OFS, 32'h0000_100C);
    sw_wr(`FW_LAST_OFS, 32'h0000_10C5);
    stat(s);
    chk(129'(s), 129'h0);
    sw_rd(`FW_BASE_OFS, st);
    chk(129'(st), 129'h1000);
    sw_rd(`FW_LAST_OFS, st);
    chk(129'(st), 129'h10C0);
    rdy_on <= 1'b1;
    send_pkt(2);
    repeat (40) @(posedge CLK_I);
    chk(129'(exp_q.size()), 129'h2);
    sw_wr(`FW_CMD_OFS, `FW_CMD_ENABLE);
    wait_drain();
    sw_wr(`FW_BASE_OFS, 32'h0000_2000);
    stat(s);
    chk(129'(s), 129'h3);
    sw_wr(`FW_CMD_OFS, 32'h0000_0007);
    stat(s);
    chk(129'(s), 129'h3);
    // random packets with an empty one; the 16-line ring wraps twice
    for (n = 0; n < 14; n++) begin
      send_pkt(n == 3 ? 0 : 1 + $urandom % 3);
      wait_drain();
    end
    // ring holds size minus one line
    for (n = 0; n < 15; n++) push_line({$urandom, $urandom, $urandom, $urandom});
    stat(s);
    chk(129'(s), 129'h1);
    push_line(128'h0);
    stat(s);
    chk(129'(s), 129'h3);
    sw_wr(`FW_CMD_OFS, `FW_CMD_RESET);
    repeat (10) @(posedge CLK_I);
    chk(129'(aborts), 129'h0);
    // abort a packet stalled in flight
    repeat (HOLD + 5) @(posedge CLK_I);
    sw_wr(`FW_CMD_OFS, `FW_CMD_ENABLE);
    rdy_on <= 1'b0;
    send_pkt(3);
    n = 0;
    while (!TX_VALID_O && n < 100) begin
      @(posedge CLK_I);
      n++;
    end
    chk(129'(TX_VALID_O), 129'h1);
    if (!TX_VALID_O) test_done();
    sw_wr(`FW_CMD_OFS, `FW_CMD_RESET);
    repeat (10) @(posedge CLK_I);
    chk(129'(aborts), 129'h1);
    exp_q.delete();
    rdy_on <= 1'b1;
    sw_wr(`FW_BASE_OFS, 32'h0000_1000);
    stat(s);
    chk(129'(s), 129'h2);
    repeat (HOLD + 5) @(posedge CLK_I);
    sw_wr(`FW_CMD_OFS, `FW_CMD_ENABLE);
    send_pkt(2);
    wait_drain();
    chk(129'(aborts), 129'h1);
    test_done();
  end
endmodule // test_mgmt_tx_ring_buffer
